/* File: inc/fpa_consts.svh */
// Constants of the fixed-point add and multiply unit
`ifndef FPA_CONSTS_SVH
`define FPA_CONSTS_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FPA_OP_SUM_INTO 6'h0c
`define FPA_OP_MINUS_INTO 6'h0d
`define FPA_OP_PLUS_MOD 6'h0e
`define FPA_OP_MINUS_MOD 6'h0f
`define FPA_OP_SUM_NEXT 6'h10
`define FPA_OP_MINUS_NEXT 6'h11
`define FPA_OP_PLUS_X 6'h14
`define FPA_OP_MINUS_X 6'h15
`define FPA_OP_PROD_DBL 6'h18
`define FPA_OP_PROD_LOW 6'h19
// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define FPA_J_IMM_ZX 4'he
`define FPA_J_IMM_SX 4'hf
`define FPA_A_CTL 4'hf
`define FPA_U_ALL1 16'hffff
// ----------------------------------------
// Timing
// ----------------------------------------
`define FPA_CLK_MHZ 10
`define FPA_T_ADD_ALT_NS 750
`define FPA_T_ADD_SAME_NS 1500
`define FPA_T_MUL_ALT_NS 2375
`define FPA_T_MUL_SAME_NS 3125
`define FPA_NS2CYC(ns) (((ns) * `FPA_CLK_MHZ + 999) / 1000)
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define FPA_SEL_ACC 2'h0
`define FPA_SEL_MOD 2'h1
`define FPA_ADR_CTL_LO 9'h100
`define FPA_ADR_CTL_HI 9'h104
`define FPA_ADR_STAT 9'h108
`endif

/* File: inc/fpa_pkg.sv */
// Types of the fixed-point add and multiply unit
package fpa_pkg;
  typedef logic [35:0] fpa_word_t;
  typedef enum logic [1:0] {FPA_IDLE, FPA_FETCH, FPA_EXEC} fpa_state_e;
  typedef struct packed {
    logic [5:0] op;
    logic [3:0] j;
    logic [3:0] a;
    logic [3:0] x;
    logic h;
    logic i;
    logic [15:0] u;
    logic same_bank;
  } fpa_instr_s;
  typedef struct packed {
    fpa_word_t sum;
    logic ovf;
    logic cry;
  } fpa_sum_s;
  typedef struct packed {
    fpa_state_e st;
    fpa_word_t [15:0] acc;
    fpa_word_t [15:0] xr;
    fpa_word_t ctl;
    logic ovf;
    logic cry;
    logic bad;
    fpa_instr_s ins;
    fpa_word_t opnd;
    logic [5:0] cnt;
    logic [5:0] lim;
    logic wreq;
    logic [31:0] rdata;
    logic done;
    logic busy;
    logic mem_rd;
    logic [17:0] mem_addr;
  } fpa_regs_s;
endpackage : fpa_pkg

/* File: logic/fpa_mul.sv */
// Ones' complement signed multiplier, double-length product
`timescale 1ns/1ps
`default_nettype none
module fpa_mul #(
  parameter int W = 36
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  output logic [2*W-1:0] prod_o
);
  logic [W-1:0] ma;
  logic [W-1:0] mb;
  logic [2*W-1:0] p;
  logic neg;

  if (W < 2) begin : g_chk
    $error("fpa_mul: W must be at least 2");
  end

  always_comb begin
    ma = a_i[W-1] ? ~a_i : a_i;
    mb = b_i[W-1] ? ~b_i : b_i;
    p = {{W{1'b0}}, ma} * {{W{1'b0}}, mb};
    // Sign from operand signs alone, so -0 factors keep it too
    neg = a_i[W-1] ^ b_i[W-1];
    prod_o = neg ? ~p : p;
  end
endmodule : fpa_mul
`default_nettype wire

/* File: logic/fpa_unit.sv */
// Fixed-point add, subtract and multiply section with Avalon register access
//
// What this block does
// - Fetch operand under partial-word selector control
// - Indexing and modifier increment work normally
// - All zeros is +0, all ones -0
// - Opcode 14: chosen plus operand into chosen
// - Opcode 15: chosen minus operand into chosen
// - Opcode 16: add operand magnitude to chosen
// - Opcode 17: subtract operand magnitude from chosen
// - Opcode 20: sum into next-higher, sources kept
// - Opcode 21: difference into next-higher, sources kept
// - Opcode 24: modifier plus operand into modifier
// - Opcode 25: modifier minus operand into modifier
// - Clear designators at start, set from result
// - Immediate all-ones u with h and i set, no index: +0 operand
// - Only -0 plus -0 gives -0
// - -0 minus +0 gives -0
// - Selector 17 octal: next-higher is control register
// - Opcode 30: product upper to chosen, lower next
// - Product bits 71 and 70 are sign
// - Sign rule holds in every multiply
// - Opcode 31: keep low product half only
// - Single-length product flagged if out of range, no correction
// - Add 0.75/1.50 us, alternate/same bank
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fpa_consts.svh"
module fpa_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [8:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic instr_valid_i,
  input wire fpa_pkg::fpa_instr_s instr_i,
  output logic busy_o,
  output logic done_o,
  output logic mem_rd_o,
  output logic [17:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [35:0] mem_data_i
);
  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam logic [5:0] C_ADD_ALT = 6'(`FPA_NS2CYC(`FPA_T_ADD_ALT_NS));
  localparam logic [5:0] C_ADD_SAME = 6'(`FPA_NS2CYC(`FPA_T_ADD_SAME_NS));
  localparam logic [5:0] C_MUL_ALT = 6'(`FPA_NS2CYC(`FPA_T_MUL_ALT_NS));
  localparam logic [5:0] C_MUL_SAME = 6'(`FPA_NS2CYC(`FPA_T_MUL_SAME_NS));

  fpa_pkg::fpa_regs_s s;
  fpa_pkg::fpa_regs_s n;
  fpa_pkg::fpa_sum_s res;
  fpa_pkg::fpa_word_t adda;
  fpa_pkg::fpa_word_t addb;
  fpa_pkg::fpa_word_t mag;
  fpa_pkg::fpa_word_t bw;
  fpa_pkg::fpa_word_t xi;
  logic [71:0] prod;
  logic [17:0] eff;
  logic [3:0] ra;
  logic [3:0] idx;
  logic req;
  logic hit;
  logic finish;
  logic st_add;
  logic st_mul;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_add(input logic [5:0] op);
    return op == `FPA_OP_SUM_INTO || op == `FPA_OP_MINUS_INTO ||
      op == `FPA_OP_PLUS_MOD || op == `FPA_OP_MINUS_MOD ||
      op == `FPA_OP_SUM_NEXT || op == `FPA_OP_MINUS_NEXT ||
      op == `FPA_OP_PLUS_X || op == `FPA_OP_MINUS_X;
  endfunction : is_add

  function automatic logic is_mul(input logic [5:0] op);
    return op == `FPA_OP_PROD_DBL || op == `FPA_OP_PROD_LOW;
  endfunction : is_mul

  function automatic fpa_pkg::fpa_sum_s oc_add(input fpa_pkg::fpa_word_t a,
                                               input fpa_pkg::fpa_word_t b);
    logic [36:0] t;
    fpa_pkg::fpa_sum_s r;
    t = {1'b0, a} + {1'b0, b};
    r.cry = t[36];
    r.sum = t[35:0] + {35'h0, t[36]};
    if ((~|a || &a) && (~|b || &b)) begin
      r.sum = (&a && &b) ? '1 : '0;
    end else if (&r.sum) begin
      // A cancelling sum of nonzero values settles on +0
      r.sum = '0;
    end
    r.ovf = (a[35] == b[35]) && (r.sum[35] != a[35]);
    return r;
  endfunction : oc_add

  function automatic logic [17:0] ix_add(input logic [17:0] a, input logic [17:0] b);
    logic [18:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[17:0] + {17'h0, t[18]};
  endfunction : ix_add

  function automatic fpa_pkg::fpa_word_t pick(input fpa_pkg::fpa_word_t m,
                                             input logic [3:0] j);
    case (j)
      4'h1: return {18'h0, m[17:0]};
      4'h2: return {18'h0, m[35:18]};
      4'h3: return {{18{m[17]}}, m[17:0]};
      4'h4: return {{18{m[35]}}, m[35:18]};
      4'h5: return {{24{m[11]}}, m[11:0]};
      4'h6: return {{24{m[23]}}, m[23:12]};
      4'h7: return {{24{m[35]}}, m[35:24]};
      4'h8: return {27'h0, m[8:0]};
      4'h9: return {27'h0, m[17:9]};
      4'ha: return {27'h0, m[26:18]};
      4'hb: return {27'h0, m[35:27]};
      4'hc: return {30'h0, m[5:0]};
      4'hd: return {30'h0, m[11:6]};
      default: return m;
    endcase
  endfunction : pick

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  fpa_mul #(
    .W(36)
  ) u_mul (
    .a_i(s.acc[s.ins.a]),
    .b_i(s.opnd),
    .prod_o(prod)
  );

  always_comb begin
    ra = s.ins.a;
    mag = s.opnd[35] ? ~s.opnd : s.opnd;
    adda = (s.ins.op == `FPA_OP_PLUS_X || s.ins.op == `FPA_OP_MINUS_X) ?
      s.xr[ra] : s.acc[ra];
    case (s.ins.op)
      `FPA_OP_MINUS_INTO, `FPA_OP_MINUS_NEXT, `FPA_OP_MINUS_X: begin
        addb = ~s.opnd;
      end
      `FPA_OP_PLUS_MOD: addb = mag;
      `FPA_OP_MINUS_MOD: addb = ~mag;
      default: addb = s.opnd;
    endcase
    res = oc_add(adda, addb);
  end

  assign finish = s.st == fpa_pkg::FPA_EXEC && s.cnt >= s.lim - 6'h1;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    n.done = 1'b0;
    req = avs_read_i | avs_write_i;
    idx = avs_address_i[6:3];
    st_add = is_add(instr_i.op);
    st_mul = is_mul(instr_i.op);
    eff = {2'h0, instr_i.u};
    xi = s.xr[instr_i.x];
    // One wait cycle for every access
    n.wreq = !(req && s.wreq);
    hit = 1'b1;
    case (avs_address_i[8:7])
      `FPA_SEL_ACC: bw = s.acc[idx];
      `FPA_SEL_MOD: bw = s.xr[idx];
      default: begin
        bw = s.ctl;
        hit = avs_address_i == `FPA_ADR_CTL_LO || avs_address_i == `FPA_ADR_CTL_HI;
      end
    endcase
    if (req && s.wreq) begin
      n.rdata = avs_address_i[2] ? {28'h0, bw[35:32]} : bw[31:0];
      if (!hit) begin
        n.rdata = '0;
      end
      if (avs_address_i == `FPA_ADR_STAT) begin
        n.rdata = {28'h0, s.bad, s.busy, s.cry, s.ovf};
      end
    end
    if (avs_write_i && !s.wreq && hit) begin
      if (avs_address_i[2]) begin
        bw[35:32] = avs_byteenable_i[0] ? avs_writedata_i[3:0] : bw[35:32];
      end else begin
        bw[31:0] = merge(bw[31:0], avs_writedata_i, avs_byteenable_i);
      end
      case (avs_address_i[8:7])
        `FPA_SEL_ACC: n.acc[idx] = bw;
        `FPA_SEL_MOD: n.xr[idx] = bw;
        default: n.ctl = bw;
      endcase
    end
    // Sequencer writes after the bus, so its result wins a collision
    case (s.st)
      fpa_pkg::FPA_IDLE: begin
        if (instr_valid_i) begin
          n.ins = instr_i;
          n.cnt = '0;
          if (instr_i.x != 4'h0) begin
            eff = ix_add(eff, xi[17:0]);
            if (instr_i.h) begin
              n.xr[instr_i.x][17:0] = ix_add(xi[17:0], xi[35:18]);
            end
          end
          if (!(st_add || st_mul)) begin
            n.done = 1'b1;
          end else begin
            n.busy = 1'b1;
            if (st_add) begin
              n.ovf = 1'b0;
              n.cry = 1'b0;
            end else begin
              n.bad = 1'b0;
            end
            if (st_mul) begin
              n.lim = instr_i.same_bank ? C_MUL_SAME : C_MUL_ALT;
            end else begin
              n.lim = instr_i.same_bank ? C_ADD_SAME : C_ADD_ALT;
            end
            if (instr_i.j == `FPA_J_IMM_ZX || instr_i.j == `FPA_J_IMM_SX) begin
              if (instr_i.x == 4'h0 && instr_i.h && instr_i.i &&
                  instr_i.u == `FPA_U_ALL1) begin
                eff = '0;
              end
              n.opnd = (instr_i.j == `FPA_J_IMM_SX) ?
                {{18{eff[17]}}, eff} : {18'h0, eff};
              n.st = fpa_pkg::FPA_EXEC;
            end else begin
              n.mem_rd = 1'b1;
              n.mem_addr = eff;
              n.st = fpa_pkg::FPA_FETCH;
            end
          end
        end
      end
      fpa_pkg::FPA_FETCH: begin
        n.cnt = s.cnt + 6'h1;
        if (mem_ack_i) begin
          n.opnd = pick(mem_data_i, s.ins.j);
          n.mem_rd = 1'b0;
          n.st = fpa_pkg::FPA_EXEC;
        end
      end
      fpa_pkg::FPA_EXEC: begin
        n.cnt = s.cnt + 6'h1;
        if (finish) begin
          if (is_add(s.ins.op)) begin
            n.ovf = res.ovf;
            n.cry = res.cry;
          end
          case (s.ins.op)
            `FPA_OP_SUM_INTO, `FPA_OP_MINUS_INTO, `FPA_OP_PLUS_MOD, `FPA_OP_MINUS_MOD: begin
              n.acc[ra] = res.sum;
            end
            `FPA_OP_SUM_NEXT, `FPA_OP_MINUS_NEXT: begin
              if (ra == `FPA_A_CTL) begin
                n.ctl = res.sum;
              end else begin
                n.acc[ra + 4'h1] = res.sum;
              end
            end
            `FPA_OP_PLUS_X, `FPA_OP_MINUS_X: begin
              n.xr[ra] = res.sum;
            end
            `FPA_OP_PROD_DBL: begin
              n.acc[ra] = prod[71:36];
              if (ra == `FPA_A_CTL) begin
                n.ctl = prod[35:0];
              end else begin
                n.acc[ra + 4'h1] = prod[35:0];
              end
            end
            `FPA_OP_PROD_LOW: begin
              n.acc[ra] = prod[35:0];
              // Flag only; the stored low half is left as is
              n.bad = !(&prod[71:35] || ~|prod[71:35]);
            end
            default: n.acc[ra] = s.acc[ra];
          endcase
          n.done = 1'b1;
          n.busy = 1'b0;
          n.st = fpa_pkg::FPA_IDLE;
        end
      end
      default: n.st = fpa_pkg::FPA_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.wreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = s.wreq;
  assign busy_o = s.busy;
  assign done_o = s.done;
  assign mem_rd_o = s.mem_rd;
  assign mem_addr_o = s.mem_addr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_done_after_busy: assert property (
    done_o && is_mul(s.ins.op) |-> $past(busy_o) && !busy_o)
    else $error("multiply done without busy period");

  a_flags_cleared: assert property (
    $rose(s.busy) && is_add(s.ins.op) |-> !s.ovf && !s.cry)
    else $error("designators not cleared at start");

  a_add_min_time: assert property (
    $rose(s.busy) && !s.ins.same_bank |-> s.busy [*8])
    else $error("add finished before least time");

  a_imm_zero: assert property (
    s.st == fpa_pkg::FPA_IDLE && instr_valid_i && (st_add || st_mul) && instr_i.x == 4'h0 &&
    instr_i.j[3:1] == 3'h7 && instr_i.h && instr_i.i && instr_i.u == `FPA_U_ALL1
    |=> s.opnd == '0)
    else $error("forced +0 operand not delivered");

  a_prod_sign: assert property (
    finish && s.ins.op == `FPA_OP_PROD_DBL |=>
    s.acc[s.ins.a][35] == s.acc[s.ins.a][34])
    else $error("product bits 71 and 70 differ");

  a_next_keeps_src: assert property (
    finish && s.ins.op == `FPA_OP_SUM_NEXT && s.ins.a != `FPA_A_CTL && !avs_write_i
    |=> s.acc[s.ins.a] == $past(s.acc[s.ins.a]))
    else $error("source accumulator modified");

  a_ctl_dest: assert property (
    finish && s.ins.op == `FPA_OP_MINUS_NEXT && s.ins.a == `FPA_A_CTL
    |=> s.ctl == $past(res.sum))
    else $error("control register not written");

  a_neg_zero_sum: assert property (
    finish && s.ins.op == `FPA_OP_SUM_INTO && &s.acc[s.ins.a] && &s.opnd
    |=> &s.acc[s.ins.a])
    else $error("-0 plus -0 not -0");

  a_low_product: assert property (
    finish && s.ins.op == `FPA_OP_PROD_LOW |=> s.acc[s.ins.a] == $past(prod[35:0]))
    else $error("low product half not stored");

  c_prod_dbl: cover property (finish && s.ins.op == `FPA_OP_PROD_DBL);
  c_prod_bad: cover property (finish && s.ins.op == `FPA_OP_PROD_LOW ##1 s.bad);
  c_add_ovf: cover property (finish && is_add(s.ins.op) && res.ovf);
  c_fetch: cover property (s.st == fpa_pkg::FPA_FETCH ##1 s.st == fpa_pkg::FPA_EXEC);
endmodule : fpa_unit
`default_nettype wire

/* File: tb/fpa_store_model.sv */
// Storage model answering operand fetches of the fixed-point unit
`timescale 1ns/1ps
`default_nettype none
module fpa_store_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mem_rd_i,
  input wire logic [17:0] mem_addr_i,
  input wire logic [7:0] delay_i,
  output logic mem_ack_o,
  output logic [35:0] mem_data_o
);
  fpa_pkg::fpa_word_t words [0:63];
  logic [7:0] wait_cnt;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      mem_data_o <= '0;
      wait_cnt <= 8'h00;
    end else begin
      mem_ack_o <= 1'b0;
      // Idle data toggles so a stale word never passes for an answer
      mem_data_o <= ~mem_data_o;
      if (mem_rd_i && !mem_ack_o) begin
        if (wait_cnt >= delay_i) begin
          mem_ack_o <= 1'b1;
          mem_data_o <= words[mem_addr_i[5:0]];
          wait_cnt <= 8'h00;
        end else begin
          wait_cnt <= wait_cnt + 8'h01;
        end
      end
    end
  end
endmodule : fpa_store_model
`default_nettype wire

/* File: tb/fpa_unit_test.sv */
// Self-checking bench of the fixed-point add and multiply unit
`timescale 1ns/1ps
`default_nettype none
module fpa_unit_test;
  logic clk, rst, rd, wr, ivalid, wait_req, busy, done, mem_rd, ack;
  logic [8:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [17:0] maddr;
  logic [35:0] mdata;
  logic [7:0] delay;
  fpa_pkg::fpa_instr_s instr;
  int fail_count, cmp_count, cyc, lat;

  always #50 clk = ~clk;

  fpa_unit dut_u (.clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .instr_valid_i(ivalid),
    .instr_i(instr), .busy_o(busy), .done_o(done), .mem_rd_o(mem_rd),
    .mem_addr_o(maddr), .mem_ack_i(ack), .mem_data_i(mdata));
  fpa_store_model mem_u (.clk_i(clk), .rst_i(rst), .mem_rd_i(mem_rd),
    .mem_addr_i(maddr), .delay_i(delay), .mem_ack_o(ack), .mem_data_o(mdata));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic [8:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wr36(input logic [8:0] a, input logic [35:0] w);
    logic [31:0] q;
    bus(a, 1'b1, w[31:0], q);
    bus(a + 9'h004, 1'b1, {28'h0, w[35:32]}, q);
  endtask : wr36

  task automatic see(input string name, input logic [8:0] a, input logic [35:0] exp);
    logic [31:0] lo, hi;
    bus(a, 1'b0, 32'h0, lo);
    bus(a + 9'h004, 1'b0, 32'h0, hi);
    chk(name, {hi[3:0], lo}, exp);
  endtask : see

  function automatic logic [8:0] ra(input int r);
    return 9'(r * 8);
  endfunction : ra

  function automatic fpa_pkg::fpa_instr_s mk(input logic [5:0] op, input logic [3:0] a,
      input logic [15:0] u, input logic [3:0] j = 4'h0, input logic [3:0] x = 4'h0,
      input logic hi = 1'b0, input logic sb = 1'b0);
    return '{op, j, a, x, hi, hi, u, sb};
  endfunction : mk

  // Held until taken on an edge with busy low; latency counted to done
  task automatic exec(input fpa_pkg::fpa_instr_s ins, output int n);
    @(posedge clk);
    instr <= ins;
    ivalid <= 1'b1;
    do @(posedge clk); while (busy !== 1'b0);
    ivalid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == 1) chk("busy while running", 36'(busy), 36'h1);
    end while (done !== 1'b1);
    n = n - 1;
  endtask : exec

  task automatic run(input fpa_pkg::fpa_instr_s ins, input int exp);
    int n;
    exec(ins, n);
    chk("latency", 36'(n), 36'(exp));
  endtask : run

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {rd, wr, ivalid} = 3'h0;
    addr = 9'h000;
    wdata = 32'h0;
    be = 4'hf;
    instr = '0;
    delay = 8'h00;
    {fail_count, cmp_count, cyc} = '0;
    mem_u.words[16] = 36'h000000003;
    mem_u.words[17] = 36'hfffffffff;
    mem_u.words[18] = ~36'h000000005;
    mem_u.words[19] = ~36'h000000001;
    mem_u.words[20] = ~36'h000000002;
    mem_u.words[32] = 36'h000000064;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr36(9'h1f0, 36'hfffffffff);
    see("unmapped", 9'h1f0, 36'h0);
    wr36(9'h108, 36'h00000000f);
    see("status read only", 9'h108, 36'h0);
    wr36(ra(1), 36'h000000005);
    run(mk(6'h0c, 4'h1, 16'h0010), 8);
    see("sum into chosen", ra(1), 36'h000000008);
    run(mk(6'h0c, 4'h1, 16'h0010, 4'h0, 4'h0, 1'b0, 1'b1), 15);
    run(mk(6'h0d, 4'h1, 16'h000b, 4'he), 8);
    see("plus minus plus", ra(1), 36'h0);
    wr36(ra(2), 36'hfffffffff);
    run(mk(6'h0c, 4'h2, 16'hffff, 4'hf, 4'h0, 1'b1), 8);
    see("neg zero plus pos", ra(2), 36'h0);
    wr36(ra(2), 36'hfffffffff);
    run(mk(6'h0c, 4'h2, 16'h0011), 8);
    see("neg zero plus neg", ra(2), 36'hfffffffff);
    run(mk(6'h0f, 4'h2, 16'h0000, 4'he), 8);
    see("neg zero minus pos", ra(2), 36'hfffffffff);
    wr36(ra(3), 36'h000000001);
    run(mk(6'h0e, 4'h3, 16'h0012), 8);
    see("plus modulus", ra(3), 36'h000000006);
    run(mk(6'h0f, 4'h3, 16'h0012), 8);
    see("minus modulus", ra(3), 36'h000000001);
    wr36(ra(4), 36'h000000007);
    run(mk(6'h10, 4'h4, 16'h0002, 4'he), 8);
    see("sum to next", ra(5), 36'h000000009);
    see("source kept", ra(4), 36'h000000007);
    wr36(ra(15), 36'h000000007);
    run(mk(6'h11, 4'hf, 16'h0002, 4'he), 8);
    see("next is control", 9'h100, 36'h000000005);
    see("source kept", ra(15), 36'h000000007);
    wr36(9'h080 + ra(3), 36'h00000000a);
    run(mk(6'h14, 4'h3, 16'h0004, 4'he), 8);
    see("plus to modifier", 9'h080 + ra(3), 36'h00000000e);
    run(mk(6'h15, 4'h3, 16'h0014, 4'he), 8);
    see("minus to modifier", 9'h080 + ra(3), ~36'h000000006);
    wr36(ra(6), 36'h7ffffffff);
    run(mk(6'h0c, 4'h6, 16'h0001, 4'he), 8);
    see("overflow", 9'h108, 36'h1);
    wr36(ra(6), ~36'h000000001);
    run(mk(6'h0c, 4'h6, 16'h0013), 8);
    see("end around", ra(6), ~36'h000000002);
    see("carry only", 9'h108, 36'h2);
    wr36(ra(7), 36'h000000003);
    run(mk(6'h18, 4'h7, 16'h0014), 24);
    see("product upper", ra(7), 36'hfffffffff);
    see("product lower", ra(8), 36'hffffffff9);
    wr36(ra(9), 36'h400000000);
    run(mk(6'h19, 4'h9, 16'h0004, 4'he, 4'h0, 1'b0, 1'b1), 32);
    see("product low", ra(9), 36'h0);
    // Multiply leaves the carry of the last add standing
    see("product invalid", 9'h108, 36'ha);
    wr36(9'h080 + ra(2), {18'h00001, 18'h00020});
    run(mk(6'h0c, 4'ha, 16'h0000, 4'h0, 4'h2, 1'b1), 8);
    see("indexed fetch", ra(10), 36'h000000064);
    see("index step", 9'h080 + ra(2), {18'h00001, 18'h00021});
    run(mk(6'h0c, 4'hc, 16'h0011, 4'h2), 8);
    see("half word pick", ra(12), 36'h00003ffff);
    delay <= 8'd20;
    exec(mk(6'h0c, 4'hb, 16'h0010), lat);
    chk("slow storage wait", 36'(lat > 20), 36'h1);
    see("slow fetch", ra(11), 36'h000000003);
    report_and_stop();
  end
endmodule : fpa_unit_test
`default_nettype wire
